// >>> core/tmbs_top.sv
// Purpose: Transmit multiframe boundary select for eight framers with a
//          16-bit non-multiplexed host port.
// Assumes: All inputs synchronous to mclk (20 MHz); host strobes are held
//          for at least two mclk cycles.
// Notes:   Host data pin is split into in, out and output enable.
`timescale 1ns/1ps
`default_nettype none
module tmbs_top
  import tmbs_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic split_strobe_mode,
  input wire tmbs_pkg::tmbs_host_req_t host_req,
  input wire logic tx_multiframe_pulse_in,
  input wire logic [tmbs_pkg::NUM_FRAMERS-1:0] frame_tick_in,
  output logic [tmbs_pkg::DATA_W-1:0] host_data_out,
  output logic host_data_oe,
  output logic [tmbs_pkg::NUM_FRAMERS-1:0] mf_start_out
);
  function automatic logic is_global(input logic [3:0] sel);
    is_global = sel[3] && sel[0] && !sel[1];
  endfunction : is_global

  function automatic logic hits_framer(input logic [3:0] sel, input int f);
    hits_framer = (sel == SEL_ALL) || (sel == 4'(f));
  endfunction : hits_framer

  tmbs_host_state_t st_reg, st_next;
  logic [ADDR_W-1:0] lat_addr_reg, lat_addr_next;
  logic lat_write_reg, lat_write_next;
  logic [DATA_W-1:0] data_out_reg, data_out_next;
  logic oe_reg, oe_next;
  logic [NUM_FRAMERS-1:0] t1_ext_superframe_select_reg, t1_sel_next;
  logic [NUM_FRAMERS-1:0] e1_ext_multiframe_enable_reg, e1_en_next;
  logic [NUM_FRAMERS-1:0] t1_esf_reg, t1_esf_next;
  logic [NUM_FRAMERS-1:0] e1_mode_reg, e1_mode_next;
  logic high_rate_reg, high_rate_next;
  logic pulse_prev_reg;
  logic pulse_fall;
  logic strobe_on, strobe_off, req_write;
  logic do_wr;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] rd_data;
  logic [IDX_W-1:0] frame_idx [NUM_FRAMERS];

  // Strobe decode for both bus styles
  always_comb
  begin
    if (split_strobe_mode)
    begin
      strobe_on = !host_req.cs_n && (!host_req.ds_rd_n || !host_req.rw_wr_n);
      req_write = !host_req.rw_wr_n;
    end
    else
    begin
      strobe_on = !host_req.cs_n && !host_req.ds_rd_n;
      req_write = !host_req.rw_wr_n;
    end
    strobe_off = !strobe_on;
  end

  // Shared strobe commits at strobe start, split strobes at write release
  always_comb
  begin
    do_wr = 1'b0;
    wr_addr = host_req.addr;
    wr_data = host_req.data;
    if (st_reg == HP_IDLE && strobe_on && req_write && !split_strobe_mode)
      do_wr = 1'b1;
    else if (st_reg == HP_BUSY && strobe_off && lat_write_reg
             && split_strobe_mode)
    begin
      do_wr = 1'b1;
      wr_addr = lat_addr_reg;
    end
  end

  // Read mux; broadcast selector reads as zero
  always_comb
  begin
    rd_data = '0;
    if (is_global(host_req.addr[11:8]))
    begin
      if (host_req.addr[7:0] == OFF_GLOBAL)
      begin
        rd_data[NUM_FRAMERS-1:0] = e1_mode_reg;
        rd_data[BIT_HIGH_RATE] = high_rate_reg;
      end
    end
    else if (host_req.addr[11:8] <= SEL_LAST_FRAMER)
    begin
      unique case (host_req.addr[7:0])
        OFF_E1_CTL:
        begin
          rd_data[BIT_E1_MF_EN] =
            e1_ext_multiframe_enable_reg[host_req.addr[10:8]];
          rd_data[BIT_T1_ESF] = t1_esf_reg[host_req.addr[10:8]];
        end
        OFF_T1_CTL:
          rd_data[BIT_T1_SF_SEL] =
            t1_ext_superframe_select_reg[host_req.addr[10:8]];
        OFF_STATUS:
          rd_data[IDX_W-1:0] = frame_idx[host_req.addr[10:8]];
        default:
          rd_data = '0;
      endcase
    end
  end

  always_comb
  begin
    st_next = st_reg;
    lat_addr_next = lat_addr_reg;
    lat_write_next = lat_write_reg;
    data_out_next = data_out_reg;
    oe_next = oe_reg;
    unique case (st_reg)
      HP_IDLE:
        if (strobe_on)
        begin
          st_next = HP_BUSY;
          lat_addr_next = host_req.addr;
          lat_write_next = req_write;
          data_out_next = rd_data;
          oe_next = !req_write;
        end
      HP_BUSY:
        if (strobe_off)
        begin
          st_next = HP_IDLE;
          oe_next = 1'b0;
        end
    endcase
  end

  // Register writes, per framer or broadcast
  always_comb
  begin
    t1_sel_next = t1_ext_superframe_select_reg;
    e1_en_next = e1_ext_multiframe_enable_reg;
    t1_esf_next = t1_esf_reg;
    e1_mode_next = e1_mode_reg;
    high_rate_next = high_rate_reg;
    if (do_wr && is_global(wr_addr[11:8]) && wr_addr[7:0] == OFF_GLOBAL)
    begin
      e1_mode_next = wr_data[NUM_FRAMERS-1:0];
      high_rate_next = wr_data[BIT_HIGH_RATE];
    end
    for (int f = 0; f < NUM_FRAMERS; f++)
    begin
      if (do_wr && hits_framer(wr_addr[11:8], f))
      begin
        if (wr_addr[7:0] == OFF_T1_CTL)
          t1_sel_next[f] = wr_data[BIT_T1_SF_SEL];
        if (wr_addr[7:0] == OFF_E1_CTL)
        begin
          e1_en_next[f] = wr_data[BIT_E1_MF_EN];
          t1_esf_next[f] = wr_data[BIT_T1_ESF];
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_reg <= HP_IDLE;
      lat_addr_reg <= '0;
      lat_write_reg <= 1'b0;
      data_out_reg <= '0;
      oe_reg <= 1'b0;
      t1_ext_superframe_select_reg <= RST_CTL;
      e1_ext_multiframe_enable_reg <= RST_CTL;
      t1_esf_reg <= RST_CTL;
      e1_mode_reg <= RST_CTL;
      high_rate_reg <= 1'b0;
      pulse_prev_reg <= RST_PULSE_PREV;
    end
    else
    begin
      st_reg <= st_next;
      lat_addr_reg <= lat_addr_next;
      lat_write_reg <= lat_write_next;
      data_out_reg <= data_out_next;
      oe_reg <= oe_next;
      t1_ext_superframe_select_reg <= t1_sel_next;
      e1_ext_multiframe_enable_reg <= e1_en_next;
      t1_esf_reg <= t1_esf_next;
      e1_mode_reg <= e1_mode_next;
      high_rate_reg <= high_rate_next;
      pulse_prev_reg <= tx_multiframe_pulse_in;
    end
  end

  // Only a falling edge counts; a level held high never aligns
  assign pulse_fall = pulse_prev_reg && !tx_multiframe_pulse_in;

  genvar g;
  generate
    for (g = 0; g < NUM_FRAMERS; g++)
    begin : g_framer
      logic ext_en;
      logic [IDX_W-1:0] mf_len;
      // Per-framer enable picked by framer mode
      assign ext_en = e1_mode_reg[g] ? e1_ext_multiframe_enable_reg[g]
                                     : t1_ext_superframe_select_reg[g];
      assign mf_len = e1_mode_reg[g] ? MF_LEN_E1
                    : (t1_esf_reg[g] ? MF_LEN_ESF : MF_LEN_D4);
      tmbs_mf_counter u_cnt (
        .mclk(mclk),
        .reset_n(reset_n),
        .frame_tick(frame_tick_in[g]),
        .ext_fall(pulse_fall),
        .ext_en(ext_en),
        .mf_len(mf_len),
        .frame_idx_reg(frame_idx[g]),
        .mf_start_reg(mf_start_out[g])
      );
    end
  endgenerate

  assign host_data_out = data_out_reg;
  assign host_data_oe = oe_reg;

  a_broadcast_write: assert property (@(posedge mclk)
    disable iff (!reset_n)
    do_wr && wr_addr[11:8] == SEL_ALL && wr_addr[7:0] == OFF_T1_CTL
    |=> t1_ext_superframe_select_reg == {8{$past(wr_data[0])}})
    else $error("broadcast write did not reach all framers");

  a_single_write: assert property (@(posedge mclk)
    disable iff (!reset_n)
    do_wr && wr_addr[11:8] == 4'h3 && wr_addr[7:0] == OFF_E1_CTL
    |=> e1_ext_multiframe_enable_reg[3] == $past(wr_data[0])
        && $stable(e1_ext_multiframe_enable_reg[2]))
    else $error("single framer write wrong");

  a_global_write: assert property (@(posedge mclk)
    disable iff (!reset_n)
    do_wr && wr_addr[11:8] == 4'h9 && wr_addr[7:0] == OFF_GLOBAL
    |=> e1_mode_reg == $past(wr_data[7:0]))
    else $error("global register write lost");

  a_oe_read_only: assert property (@(posedge mclk)
    disable iff (!reset_n)
    host_data_oe |-> st_reg == HP_BUSY && !lat_write_reg)
    else $error("data driven outside a read");

  a_broadcast_read: assert property (@(posedge mclk)
    disable iff (!reset_n)
    st_reg == HP_IDLE && strobe_on && !req_write
    && host_req.addr[11:8] == SEL_ALL |=> host_data_out == '0)
    else $error("broadcast selector returned read data");
endmodule : tmbs_top
`default_nettype wire

// >>> core/tmbs_pkg.sv
// Purpose: Shared constants and types for the transmit multiframe boundary
//          select block.
// Assumes: Host port of 16 data bits and 12 address bits.
// Notes:   Field positions and offsets are used by the top.
package tmbs_pkg;
  localparam int NUM_FRAMERS = 8;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int IDX_W = 5;

  // Upper address nibble values
  localparam logic [3:0] SEL_ALL = 4'h8;
  localparam logic [3:0] SEL_LAST_FRAMER = 4'h7;

  // Framer-relative offsets (low address byte)
  localparam logic [7:0] OFF_E1_CTL = 8'h02;
  localparam logic [7:0] OFF_STATUS = 8'h03;
  localparam logic [7:0] OFF_T1_CTL = 8'hf1;
  // Global register offset
  localparam logic [7:0] OFF_GLOBAL = 8'h00;

  // Field positions
  localparam int BIT_E1_MF_EN = 0;
  localparam int BIT_T1_ESF = 1;
  localparam int BIT_T1_SF_SEL = 0;
  localparam int BIT_HIGH_RATE = 8;

  // Multiframe lengths in basic frames
  localparam logic [IDX_W-1:0] MF_LEN_D4 = 5'h0c;
  localparam logic [IDX_W-1:0] MF_LEN_ESF = 5'h18;
  localparam logic [IDX_W-1:0] MF_LEN_E1 = 5'h10;

  // Reset values
  localparam logic [NUM_FRAMERS-1:0] RST_CTL = 8'h00;
  localparam logic RST_PULSE_PREV = 1'b1;

  typedef enum logic [0:0] {
    HP_IDLE = 1'b0,
    HP_BUSY = 1'b1
  } tmbs_host_state_t;

  typedef struct packed {
    logic cs_n;
    logic ds_rd_n;
    logic rw_wr_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } tmbs_host_req_t;
endpackage : tmbs_pkg

// >>> core/tmbs_mf_counter.sv
// Purpose: Per-framer transmit multiframe counter.
// Assumes: frame_tick marks the start of each basic frame of this framer.
// Notes:   An enabled external falling edge forces frame 0.
`timescale 1ns/1ps
`default_nettype none
module tmbs_mf_counter
  import tmbs_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic frame_tick,
  input wire logic ext_fall,
  input wire logic ext_en,
  input wire logic [tmbs_pkg::IDX_W-1:0] mf_len,
  output logic [tmbs_pkg::IDX_W-1:0] frame_idx_reg,
  output logic mf_start_reg
);
  logic [IDX_W-1:0] frame_idx_next;
  logic mf_start_next;

  always_comb
  begin
    frame_idx_next = frame_idx_reg;
    mf_start_next = 1'b0;
    if (ext_en && ext_fall)
    begin
      frame_idx_next = '0;
      mf_start_next = 1'b1;
    end
    else if (frame_tick)
    begin
      // Edges are ignored here when not enabled
      if (frame_idx_reg >= mf_len - 5'h01)
        frame_idx_next = '0;
      else
        frame_idx_next = frame_idx_reg + 5'h01;
      mf_start_next = (frame_idx_next == '0);
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      frame_idx_reg <= '0;
      mf_start_reg <= 1'b0;
    end
    else
    begin
      frame_idx_reg <= frame_idx_next;
      mf_start_reg <= mf_start_next;
    end
  end

  a_fall_aligns: assert property (@(posedge mclk)
    disable iff (!reset_n)
    ext_en && ext_fall |=> frame_idx_reg == '0 && mf_start_reg)
    else $error("enabled falling edge did not force frame 0");

  a_ignore_disabled: assert property (@(posedge mclk)
    disable iff (!reset_n)
    !ext_en && ext_fall && !frame_tick |=> $stable(frame_idx_reg))
    else $error("disabled framer reacted to pulse edge");

  a_wrap_len: assert property (@(posedge mclk)
    disable iff (!reset_n)
    frame_tick && !(ext_en && ext_fall) && frame_idx_reg == mf_len - 5'h01
    |=> frame_idx_reg == '0 && mf_start_reg)
    else $error("internal multiframe did not wrap at its length");
endmodule : tmbs_mf_counter
`default_nettype wire

// >>> tb/tmbs_partner.sv
// Purpose: Backplane timing source for the multiframe select bench.
// Assumes: Commands are sampled on the rising edge of mclk.
// Notes:   Framer k sees a frame start every k+3 cycles while run is high.
`timescale 1ns/1ps
`default_nettype none
module tmbs_partner
  import tmbs_pkg::*;
(
  input wire logic mclk,
  input wire logic run,
  input wire logic pulse_low,
  output logic pulse,
  output logic [tmbs_pkg::NUM_FRAMERS-1:0] ticks
);
  int cnt [NUM_FRAMERS];
  logic go;
  logic low;
  initial
  begin
    pulse = 1'b1;
    ticks = '0;
    foreach (cnt[k]) cnt[k] = 0;
  end
  always @(posedge mclk)
  begin
    go = run;
    low = pulse_low;
    #1;
    pulse = !low;
    for (int k = 0; k < NUM_FRAMERS; k++)
    begin
      cnt[k] = go ? (cnt[k] + 1) % (k + 3) : 0;
      ticks[k] = go && cnt[k] == 0;
    end
  end
endmodule : tmbs_partner
`default_nettype wire

// >>> tb/tb.sv
// Purpose: Self-checking bench for the multiframe boundary select block.
// Assumes: Inputs change 1 ns after the rising edge of mclk.
// Notes:   A frame index model mirrors every framer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) check_val(n, e, s)
module tb;
  import tmbs_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic split_strobe_mode = 1'b0;
  logic run = 1'b0;
  logic pl = 1'b0;
  logic fall;
  logic eprev;
  logic pulse;
  logic host_data_oe;
  logic [15:0] host_data_out;
  logic [7:0] ticks, mf_start_out, ems, e1m, en_e1, esf, t1s;
  logic [4:0] eidx [8];
  tmbs_host_req_t host_req = '{1'b1, 1'b1, 1'b1, 12'h000, 16'h0000};
  integer seed = 32'hfbd2c6dc;
  int fail_count = 0;
  int check_count = 0;
  always #25 mclk = ~mclk;
  tmbs_top dut_u (.mclk(mclk), .reset_n(reset_n),
    .split_strobe_mode(split_strobe_mode),
    .host_req(host_req), .tx_multiframe_pulse_in(pulse),
    .frame_tick_in(ticks), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe), .mf_start_out(mf_start_out));
  tmbs_partner src_u (.mclk(mclk), .run(run), .pulse_low(pl),
    .pulse(pulse), .ticks(ticks));
  task automatic check_val(string n, logic [15:0] e, logic [15:0] s);
    check_count++;
    if (s !== e)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask : check_val
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop
  function automatic logic [4:0] mf_len(int k);
    return e1m[k] ? MF_LEN_E1 : (esf[k] ? MF_LEN_ESF : MF_LEN_D4);
  endfunction : mf_len
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      foreach (eidx[k]) eidx[k] = 5'h00;
      ems = 8'h00;
      eprev = 1'b1;
    end
    else
    begin
      fall = !pulse && eprev;
      eprev = pulse;
      for (int k = 0; k < NUM_FRAMERS; k++)
      begin
        ems[k] = 1'b0;
        if (fall && (e1m[k] ? en_e1[k] : t1s[k]))
        begin
          eidx[k] = 5'h00;
          ems[k] = 1'b1;
        end
        else if (ticks[k])
        begin
          ems[k] = eidx[k] == mf_len(k) - 5'h01;
          eidx[k] = ems[k] ? 5'h00 : eidx[k] + 5'h01;
        end
      end
    end
  end
  always @(negedge mclk)
    if (reset_n) `CHK("mf_start", {8'h00, ems}, {8'h00, mf_start_out});
  task automatic cyc(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  // One host access; held three edges, then idle two
  task automatic bus(logic wr, logic [11:0] a, logic [15:0] d,
    logic [15:0] e);
    host_req = '{1'b0, wr && split_strobe_mode, !wr, a, d};
    cyc(3);
    if (!wr) `CHK("read data", e, host_data_out);
    `CHK("data enable", {15'h0, !wr}, {15'h0, host_data_oe});
    host_req = '{1'b1, 1'b1, 1'b1, a, d};
    cyc(2);
    `CHK("enable idle", 16'h0000, {15'h0, host_data_oe});
  endtask : bus
  task automatic phase(logic split, logic rate);
    logic [15:0] r;
    reset_n = 1'b0;
    run = 1'b0;
    pl = 1'b0;
    split_strobe_mode = split;
    {e1m, en_e1, esf, t1s} = '0;
    cyc(12);
    reset_n = 1'b1;
    bus(1'b0, 12'h503, 16'h0000, 16'h0000);
    r = 16'($random(seed)) & 16'h0003;
    bus(1'b1, 12'h802, r, 16'h0000);
    en_e1 = {8{r[0]}};
    esf = {8{r[1]}};
    bus(1'b0, 12'h302, 16'h0000, r);
    bus(1'b1, {SEL_ALL, OFF_T1_CTL}, 16'h0001, 16'h0000);
    bus(1'b0, {4'h6, OFF_T1_CTL}, 16'h0000, 16'h0001);
    for (int k = 0; k < NUM_FRAMERS; k++)
    begin
      r = 16'($random(seed));
      if (k % 2 == 1)
      begin
        bus(1'b1, {4'(k), OFF_E1_CTL}, r & 16'h0003, 16'h0000);
        {esf[k], en_e1[k]} = r[1:0];
      end
      bus(1'b1, {4'(k), OFF_T1_CTL}, {15'h0, r[2]}, 16'h0000);
      t1s[k] = r[2];
      bus(1'b0, {4'(k), OFF_T1_CTL}, 16'h0000, {15'h0, r[2]});
    end
    e1m = 8'($random(seed));
    bus(1'b1, {4'h9, OFF_GLOBAL}, {7'h00, rate, e1m}, 16'h0000);
    bus(1'b0, {4'hd, OFF_GLOBAL}, 16'h0000, {7'h00, rate, e1m});
    bus(1'b0, {SEL_ALL, OFF_GLOBAL}, 16'h0000, 16'h0000);
    bus(1'b0, 12'h055, 16'h0000, 16'h0000);
    run = 1'b1;
    cyc(40);
    pl = 1'b1;
    cyc(3);
    pl = 1'b0;
    cyc(50);
    pl = 1'b1;
    cyc(1);
    pl = 1'b0;
    cyc(60);
    run = 1'b0;
    cyc(2);
    for (int k = 0; k < NUM_FRAMERS; k++)
      bus(1'b0, {4'(k), OFF_STATUS}, 16'h0000, {11'h0, eidx[k]});
  endtask : phase
  initial
  begin
    #200000;
    fail_count++;
    report_and_stop();
  end
  initial
  begin
    phase(1'b0, 1'b0);
    phase(1'b1, 1'b1);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
